// ==== tpcg_pkg.sv ====
// Package of constants for the two-phase clock generator
package tpcg_pkg;
    localparam int         SLOT_COUNT    = 9;
    localparam logic [3:0] SLOT_LAST     = 4'h8;
    localparam logic [3:0] PH1_FIRST     = 4'h0;
    localparam logic [3:0] PH1_LAST      = 4'h1;
    localparam logic [3:0] PH2_FIRST     = 4'h4;
    localparam logic [3:0] PH2_LAST      = 4'h8;
    localparam logic [3:0] STROBE_SLOT   = 4'h1;
    localparam logic [3:0] SYNC_SAMPLE   = 4'h8;
    localparam logic [3:0] RESYNC_SLOT   = 4'h7;
    localparam logic [3:0] OSC_DIV_HALF  = 4'h1;
    localparam logic [3:0] RESET_CYCLES  = 4'h3;
    localparam logic [3:0] POWERUP_CYCLES = 4'h4;
    localparam logic [3:0] HOLD_LAST     = 4'hf;
endpackage : tpcg_pkg

// ==== tpcg_sync_if.sv ====
// Interface carrying sampled oscillator and sync levels to the timer
`timescale 1ns/1ps
interface tpcg_sync_if;
    logic osc_level;
    logic osc_rise;
    logic sync_level;
    modport source (output osc_level, output osc_rise, output sync_level);
    modport sink   (input  osc_level, input  osc_rise, input  sync_level);
endinterface : tpcg_sync_if

// ==== tpcg_input_sync.sv ====
// Two-flop synchronisers for pin inputs and oscillator edge detect
`timescale 1ns/1ps
module tpcg_input_sync
    import tpcg_pkg::*;
(
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // Raw pins
    input  wire logic crystal_in,
    input  wire logic sync_in,
    input  wire logic ready_request_in,
    input  wire logic reset_request_in,
    // Synchronised levels
    output logic      ready_level_out,
    output logic      reset_level_out,
    tpcg_sync_if.source sig
);
    logic [1:0] osc_meta;
    logic [1:0] sync_meta;
    logic [1:0] rdy_meta;
    logic [1:0] rst_meta;
    logic       osc_prev;

    // First stage feeds only the second stage
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            osc_meta  <= 2'h0;
            sync_meta <= 2'h0;
            rdy_meta  <= 2'h0;
            rst_meta  <= 2'h0;
            osc_prev  <= 1'h0;
        end
        else
        begin
            osc_meta  <= {osc_meta[0], crystal_in};
            sync_meta <= {sync_meta[0], sync_in};
            rdy_meta  <= {rdy_meta[0], ready_request_in};
            rst_meta  <= {rst_meta[0], reset_request_in};
            osc_prev  <= osc_meta[1];
        end
    end

    assign sig.osc_level    = osc_meta[1];
    assign sig.osc_rise     = osc_meta[1] & ~osc_prev;
    assign sig.sync_level   = sync_meta[1];
    assign ready_level_out  = rdy_meta[1];
    assign reset_level_out  = rst_meta[1];
endmodule : tpcg_input_sync

// ==== tpcg_clock_gen.sv ====
// Two-phase clock generator top: divide by nine, strobe, ready and reset
`timescale 1ns/1ps
module tpcg_clock_gen
    import tpcg_pkg::*;
(
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_in,
    // Oscillator and processor inputs
    input  wire logic crystal_pin_a_in,
    input  wire logic sync_in,
    input  wire logic ready_request_in,
    input  wire logic reset_request_in,
    // Processor clocks
    output logic      phase_one_clock_out,
    output logic      phase_two_clock_out,
    output logic      phase_two_logic_level_out,
    output logic      oscillator_out,
    // Processor control
    output logic      status_strobe_n_out,
    output logic      ready_out,
    output logic      reset_out
);
    tpcg_sync_if sig ();
    logic       ready_level;
    logic       reset_level;
    logic [3:0] slot;
    logic [3:0] pu_count;
    logic [3:0] rst_count;
    logic       ready_sample;
    logic       sync_seen;
    logic       reset_hold;

    tpcg_input_sync u_sync (
        .clock_in         (clock_in),
        .rst_in           (rst_in),
        .crystal_in       (crystal_pin_a_in),
        .sync_in          (sync_in),
        .ready_request_in (ready_request_in),
        .reset_request_in (reset_request_in),
        .ready_level_out  (ready_level),
        .reset_level_out  (reset_level),
        .sig              (sig)
    );

    function automatic logic in_range(input logic [3:0] s,
                                      input logic [3:0] lo,
                                      input logic [3:0] hi);
        in_range = (s >= lo) && (s <= hi);
    endfunction : in_range

    // Slot counter advances on each oscillator rise
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            slot <= 4'h0;
        else if (sig.osc_rise)
            slot <= (slot == SLOT_LAST) ? 4'h0 : slot + 4'h1;
    end

    // Phases registered from slot so they never overlap
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            phase_one_clock_out       <= 1'h0;
            phase_two_clock_out       <= 1'h0;
            phase_two_logic_level_out <= 1'h0;
            oscillator_out            <= 1'h0;
        end
        else
        begin
            phase_one_clock_out <= in_range(slot, PH1_FIRST, PH1_LAST);
            phase_two_clock_out <= in_range(slot, PH2_FIRST, PH2_LAST);
            phase_two_logic_level_out
                <= in_range(slot, PH2_FIRST, PH2_LAST);
            oscillator_out      <= sig.osc_level;
        end
    end

    // Sync is sampled late in phase two, strobe falls in the next cycle
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync_seen           <= 1'h0;
            status_strobe_n_out <= 1'h1;
        end
        else
        begin
            if (sig.osc_rise && slot == SYNC_SAMPLE)
                sync_seen <= sig.sync_level;
            // Slot one sits six slots after phase two rose
            status_strobe_n_out
                <= ~(sync_seen && slot == STROBE_SLOT);
        end
    end

    // Ready sampled on every oscillator rise, handed to the processor late in
    // phase two so it is steady across the processor's sampling window
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ready_sample <= 1'h0;
            ready_out    <= 1'h0;
        end
        else if (sig.osc_rise)
        begin
            ready_sample <= ready_level;
            if (slot == RESYNC_SLOT)
                ready_out <= ready_sample;
        end
    end

    // Power-up counter keeps reset alive for several processor cycles
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pu_count   <= 4'h0;
            rst_count  <= 4'h0;
            reset_hold <= 1'h1;
            reset_out  <= 1'h1;
        end
        else
        begin
            if (sig.osc_rise && slot == RESYNC_SLOT)
            begin
                if (pu_count != POWERUP_CYCLES)
                    pu_count <= pu_count + 4'h1;
                if (reset_level)
                    rst_count <= 4'h0;
                else if (rst_count != HOLD_LAST)
                    rst_count <= rst_count + 4'h1;
                reset_hold <= reset_level
                    || (pu_count != POWERUP_CYCLES)
                    || (rst_count < RESET_CYCLES);
            end
            reset_out <= reset_hold;
        end
    end
endmodule : tpcg_clock_gen

// ==== tpcg_clock_gen_properties.sv ====
// Pin timing checks for the two-phase clock generator
`timescale 1ns/1ps
module tpcg_clock_gen_properties (
    // Watched pins
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic crystal_pin_a_in,
    input wire logic phase_one_clock_out,
    input wire logic phase_two_clock_out,
    input wire logic phase_two_logic_level_out,
    input wire logic oscillator_out,
    input wire logic status_strobe_n_out,
    input wire logic ready_out
);
    wire ph1 = phase_one_clock_out, ph2 = phase_two_clock_out;
    wire stb_n = status_strobe_n_out, ttl = phase_two_logic_level_out;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_no_overlap: assert property (!(ph1&&ph2)) else $error("overlap");
    a_ttl_copy: assert property (ttl == ph2) else $error("ttl");
    a_strobe_width: assert property (
        $fell(stb_n) |-> (!stb_n)[*8] ##1 stb_n) else $error("strobe width");
    a_strobe_slot: assert property (!stb_n |-> ph1)
        else $error("strobe slot");
    // The first phase one after reset is cut short, so only a phase one
    // that follows a full phase two is timed
    a_ph1_timing: assert property ($rose(ph1) && $fell(ph2) |->
        ##15 ph1 ##1 !ph1 ##15 !ph2 ##1 ph2) else $error("phase one");
    a_ph2_timing: assert property ($rose(ph2) |-> ##39 ph2
        ##1 (!ph2 && ph1)) else $error("phase two");
    a_ready_slot: assert property ($changed(ready_out) |-> ph2)
        else $error("ready");
    a_osc_copy: assert property ($changed(oscillator_out) |->
        oscillator_out == crystal_pin_a_in) else $error("osc");
    c_strobe: cover property ($fell(stb_n));
    c_full_cycle: cover property ($rose(ph1) && $fell(ph2));
    c_ready_up: cover property ($rose(ready_out));
    c_ready_down: cover property ($fell(ready_out));
endmodule : tpcg_clock_gen_properties

// ==== tpcg_cpu_model.sv ====
// Processor model that raises sync through phase two
`timescale 1ns/1ps
module tpcg_cpu_model (
    // Phase clocks in, sync out
    input  wire logic ph1_in,
    input  wire logic ph2_in,
    input  wire logic enable_in,
    output logic      sync_out
);
    initial sync_out = 1'h0;
    // Edges only: a late enable waits a cycle, as a processor would
    always @(posedge ph1_in or posedge ph2_in)
        sync_out <= ph2_in && enable_in;
endmodule : tpcg_cpu_model

// ==== tpcg_clock_gen_bench.sv ====
// Self-checking bench for the two-phase clock generator
`timescale 1ns/1ps
module tpcg_clock_gen_bench;
    logic clock_in = 1'h0, rst_in = 1'h1, crystal_pin_a_in = 1'h0, en = 1'h0;
    logic ready_request_in = 1'h0, reset_request_in = 1'h0, sync_in;
    logic phase_one_clock_out, phase_two_clock_out, phase_two_logic_level_out;
    logic oscillator_out, status_strobe_n_out, ready_out, reset_out;
    int miscompares = 0, compares = 0, cyc = 0, n = 0;
    int base = 0;
    logic stb_prev = 1'h1;
    logic [2:0] rows [4] = '{3'h0, 3'h7, 3'h4, 3'h2};
    tpcg_clock_gen i_dut (
        .clock_in                  (clock_in),
        .rst_in                    (rst_in),
        .crystal_pin_a_in          (crystal_pin_a_in),
        .sync_in                   (sync_in),
        .ready_request_in          (ready_request_in),
        .reset_request_in          (reset_request_in),
        .phase_one_clock_out       (phase_one_clock_out),
        .phase_two_clock_out       (phase_two_clock_out),
        .phase_two_logic_level_out (phase_two_logic_level_out),
        .oscillator_out            (oscillator_out),
        .status_strobe_n_out       (status_strobe_n_out),
        .ready_out                 (ready_out),
        .reset_out                 (reset_out)
    );
    tpcg_cpu_model i_cpu (.ph1_in(phase_one_clock_out),
        .ph2_in(phase_two_clock_out), .enable_in(en), .sync_out(sync_in));
    initial forever #12.5 clock_in = ~clock_in;
    initial #1 forever #100 crystal_pin_a_in = ~crystal_pin_a_in;
    // Strobe falls counted here only; ceiling far above the run's length
    always @(posedge clock_in)
    begin
        stb_prev <= status_strobe_n_out;
        if (stb_prev && !status_strobe_n_out)
            n <= n + 1;
        cyc <= cyc + 1;
        if (cyc == 10000)
            print_verdict(1'h1);
    end
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        miscompares += (s !== e);
    endtask : check
    task automatic step(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask : step
    task automatic print_verdict(input bit hung);
        miscompares += hung;
        $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    initial
    begin
        step(3);
        rst_in = 1'h0;
        step(200);
        check(reset_out, 8'h01);
        step(200);
        check(reset_out, 8'h00);
        $display("Power-up reset test done");
        foreach (rows[i])
        begin
            @(posedge phase_two_clock_out);
            step(16);
            {en, ready_request_in, reset_request_in} = rows[i];
            step(144);
            check(reset_out, 8'(rows[i][0] | (i > 0 && rows[i-1][0])));
            base = n;
            step(216);
            check(8'(n - base), 8'(3 * rows[i][2]));
            check(ready_out, rows[i][1]);
            check(reset_out, rows[i][0]);
            $display("Row %0d done", i);
        end
        // Reset dropped in mid-cycle, during phase two
        @(posedge phase_two_clock_out);
        step(8);
        rst_in = 1'h1;
        step(2);
        check(phase_one_clock_out, 8'h00);
        check(phase_two_clock_out, 8'h00);
        check(phase_two_logic_level_out, 8'h00);
        check(oscillator_out, 8'h00);
        check(status_strobe_n_out, 8'h01);
        check(ready_out, 8'h00);
        check(reset_out, 8'h01);
        rst_in = 1'h0;
        step(2);
        check(phase_one_clock_out, 8'h01);
        check(phase_two_clock_out, 8'h00);
        check(reset_out, 8'h01);
        step(200);
        check(reset_out, 8'h01);
        step(200);
        check(reset_out, 8'h00);
        $display("Mid-run reset test done");
        print_verdict(1'h0);
    end
endmodule : tpcg_clock_gen_bench
bind tpcg_clock_gen tpcg_clock_gen_properties i_prop (
    .clock_in                  (clock_in),
    .rst_in                    (rst_in),
    .crystal_pin_a_in          (crystal_pin_a_in),
    .phase_one_clock_out       (phase_one_clock_out),
    .phase_two_clock_out       (phase_two_clock_out),
    .phase_two_logic_level_out (phase_two_logic_level_out),
    .oscillator_out            (oscillator_out),
    .status_strobe_n_out       (status_strobe_n_out),
    .ready_out                 (ready_out)
);
